// [verilog/lie_events_low.sv]
// Chosen here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
// Notes on behaviour
// - phy status request sets bit 19
// - failed access without link clock sets 18
// - bus reset entry sets bit 17
// - identity stream done sets bit 16
// - bus reset clears bit 16 same cycle
// - bit 15 set with 16, software clear only
// - bits 14 to 10 read zero, ignore writes
// - lock response without ack_complete sets 9
// - posted write host error sets bit 8
// - bit 7 is live masked iso rx OR
// - bit 6 is live masked iso tx OR
// - response packet stored sets bit 5
// - request packet stored sets bit 4
// - rx response descriptor done may set 3
// - rx request descriptor done may set 2
// - tx response command done may set 1
// - tx request command done may set 0
// - clear address read returns events AND mask
module lie_events_low (
    input  wire logic                  i_clk,
    input  wire logic                  i_nrst,
    // ahb-lite slave
    input  wire logic                  i_hsel,
    input  wire logic [31:0]           i_haddr,
    input  wire logic [1:0]            i_htrans,
    input  wire logic                  i_hwrite,
    input  wire logic [2:0]            i_hsize,
    input  wire logic [31:0]           i_hwdata,
    input  wire logic                  i_hready,
    output logic      [31:0]           o_hrdata,
    output logic                       o_hreadyout,
    output logic                       o_hresp,
    // event sources, one-cycle pulses
    input  wire logic                  i_phy_status_irq,
    input  wire logic                  i_register_access_fail,
    input  wire logic                  i_bus_reset,
    input  wire logic                  i_identity_stream_done,
    input  wire logic                  i_lock_response_error,
    input  wire logic                  i_posted_write_error,
    input  wire logic                  i_response_packet_stored,
    input  wire logic                  i_request_packet_stored,
    input  wire logic                  i_arx_rsp_done,
    input  wire logic                  i_arx_rsp_irq_req,
    input  wire logic                  i_arx_req_done,
    input  wire logic                  i_arx_req_irq_req,
    input  wire logic                  i_atx_rsp_done,
    input  wire logic                  i_atx_rsp_irq_req,
    input  wire logic                  i_atx_req_done,
    input  wire logic                  i_atx_req_irq_req,
    // isochronous per-context events and masks, levels
    input  wire logic [7:0]            i_iso_rx_events,
    input  wire logic [7:0]            i_iso_rx_mask,
    input  wire logic [7:0]            i_iso_tx_events,
    input  wire logic [7:0]            i_iso_tx_mask,
    // interrupt mask register bits 19..0, level
    input  wire logic [19:0]           i_event_mask,
    // event view for the interrupt combiner
    output logic      [19:0]           o_events
);

    typedef struct packed {
        logic [19:0] ev;
        logic        wr_pend;
        logic [1:0]  sel;
        logic [31:0] rdata;
        logic        ready;
        logic [19:0] view;
    } lie_state_t;

    lie_state_t s_q;
    lie_state_t s_d;
    logic [19:0] hw_set;
    logic [19:0] sw_set;
    logic [19:0] sw_clr;
    logic        iso_rx_sum;
    logic        iso_tx_sum;
    logic        addr_ok;
    logic [1:0]  addr_sel;

    // next state: events, bus address and data phases
    always_comb begin
        s_d    = s_q;
        hw_set = '0;
        hw_set[lie_pkg::LIE_BIT_PHY_REQ]  = i_phy_status_irq;
        hw_set[lie_pkg::LIE_BIT_REG_FAIL] = i_register_access_fail;
        hw_set[lie_pkg::LIE_BIT_BUS_RESET] = i_bus_reset;
        hw_set[lie_pkg::LIE_BIT_ID_DONE]  = i_identity_stream_done;
        hw_set[lie_pkg::LIE_BIT_ID_DONE_STICKY] =
            i_identity_stream_done;
        hw_set[lie_pkg::LIE_BIT_LOCK_ERR] = i_lock_response_error;
        hw_set[lie_pkg::LIE_BIT_POSTED_ERR] = i_posted_write_error;
        hw_set[lie_pkg::LIE_BIT_RSP_PKT]  = i_response_packet_stored;
        hw_set[lie_pkg::LIE_BIT_REQ_PKT]  = i_request_packet_stored;
        hw_set[lie_pkg::LIE_BIT_ARX_RSP]  =
            i_arx_rsp_done & i_arx_rsp_irq_req;
        hw_set[lie_pkg::LIE_BIT_ARX_REQ]  =
            i_arx_req_done & i_arx_req_irq_req;
        hw_set[lie_pkg::LIE_BIT_ATX_RSP]  =
            i_atx_rsp_done & i_atx_rsp_irq_req;
        hw_set[lie_pkg::LIE_BIT_ATX_REQ]  =
            i_atx_req_done & i_atx_req_irq_req;

        // software write lands in the data phase
        sw_set = '0;
        sw_clr = '0;
        if (s_q.wr_pend && s_q.sel == lie_pkg::LIE_SEL_SET) begin
            sw_set = i_hwdata[19:0] & lie_pkg::LIE_LATCHED;
        end
        if (s_q.wr_pend && s_q.sel == lie_pkg::LIE_SEL_CLEAR) begin
            sw_clr = i_hwdata[19:0] & lie_pkg::LIE_LATCHED;
        end

        // hardware set wins over a software clear
        s_d.ev = ((s_q.ev | sw_set) & ~sw_clr) | hw_set;
        if (i_bus_reset) begin
            s_d.ev[lie_pkg::LIE_BIT_ID_DONE] = 1'b0;
        end
        s_d.ev = s_d.ev & lie_pkg::LIE_LATCHED;

        // live isochronous summaries
        iso_rx_sum = |(i_iso_rx_events & i_iso_rx_mask);
        iso_tx_sum = |(i_iso_tx_events & i_iso_tx_mask);
        s_d.view = s_d.ev;
        s_d.view[lie_pkg::LIE_BIT_ISO_RX] = iso_rx_sum;
        s_d.view[lie_pkg::LIE_BIT_ISO_TX] = iso_tx_sum;

        // address decode
        addr_ok  = i_hsel && i_htrans[1] && i_hready;
        addr_sel = lie_pkg::LIE_SEL_NONE;
        if (i_haddr[31:12] == 20'h00000) begin
            if (i_haddr[11:0] == lie_pkg::LIE_OFS_EVENT_SET) begin
                addr_sel = lie_pkg::LIE_SEL_SET;
            end else if (i_haddr[11:0] == lie_pkg::LIE_OFS_EVENT_CLEAR) begin
                addr_sel = lie_pkg::LIE_SEL_CLEAR;
            end
        end

        // address phase: latch target, prepare read data
        s_d.ready = 1'b1;
        if (addr_ok) begin
            s_d.wr_pend = i_hwrite;
            s_d.sel     = addr_sel;
            if (!i_hwrite) begin
                unique case (addr_sel)
                    lie_pkg::LIE_SEL_SET: begin
                        s_d.rdata = {12'h000, s_d.view};
                    end
                    lie_pkg::LIE_SEL_CLEAR: begin
                        s_d.rdata = {12'h000,
                                     s_d.view & i_event_mask};
                    end
                    default: begin
                        s_d.rdata = 32'h0000_0000;
                    end
                endcase
            end
        end else if (i_hready) begin
            s_d.wr_pend = 1'b0;
            s_d.sel     = lie_pkg::LIE_SEL_NONE;
        end
    end

    // state register
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            s_q       <= '0;
            s_q.ready <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flops, hresp tied to okay
    assign o_hrdata    = s_q.rdata;
    assign o_hreadyout = s_q.ready;
    assign o_hresp     = lie_pkg::LIE_HRESP_OKAY;
    assign o_events    = s_q.view;

    // bus sequences
    sequence s_rd_clear;
        i_hsel && i_htrans[1] && i_hready && !i_hwrite &&
        i_haddr == {20'h00000, lie_pkg::LIE_OFS_EVENT_CLEAR};
    endsequence

    sequence s_wr_set;
        i_hsel && i_htrans[1] && i_hready && i_hwrite &&
        i_haddr == {20'h00000, lie_pkg::LIE_OFS_EVENT_SET};
    endsequence

    sequence s_wr_clear;
        i_hsel && i_htrans[1] && i_hready && i_hwrite &&
        i_haddr == {20'h00000, lie_pkg::LIE_OFS_EVENT_CLEAR};
    endsequence

    sequence s_rd_set;
        i_hsel && i_htrans[1] && i_hready && !i_hwrite &&
        i_haddr == {20'h00000, lie_pkg::LIE_OFS_EVENT_SET};
    endsequence

    property p_phy;
        @(posedge i_clk) disable iff (!i_nrst)
        i_phy_status_irq |=> o_events[19];
    endproperty
    a_phy: assert property (p_phy) else $error("bit 19 not set");

    property p_reg_fail;
        @(posedge i_clk) disable iff (!i_nrst)
        i_register_access_fail |=> o_events[18];
    endproperty
    a_reg_fail: assert property (p_reg_fail)
        else $error("bit 18 not set");

    property p_bus_reset;
        @(posedge i_clk) disable iff (!i_nrst)
        i_bus_reset |=> o_events[17] && !o_events[16];
    endproperty
    a_bus_reset: assert property (p_bus_reset)
        else $error("bus reset bits wrong");

    property p_id_done;
        @(posedge i_clk) disable iff (!i_nrst)
        i_identity_stream_done && !i_bus_reset |=> o_events[16];
    endproperty
    a_id_done: assert property (p_id_done)
        else $error("bit 16 not set");

    property p_id_clear;
        @(posedge i_clk) disable iff (!i_nrst)
        i_bus_reset && i_identity_stream_done |=> !o_events[16];
    endproperty
    a_id_clear: assert property (p_id_clear)
        else $error("bit 16 survived bus reset");

    property p_sticky;
        @(posedge i_clk) disable iff (!i_nrst)
        o_events[15] && !s_q.wr_pend ##0 i_bus_reset |=> o_events[15];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("bit 15 lost on bus reset");

    property p_reserved;
        @(posedge i_clk) disable iff (!i_nrst)
        1'b1 |-> o_events[14:10] == 5'h00 && o_hrdata[14:10] == 5'h00;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved bits nonzero");

    property p_errors;
        @(posedge i_clk) disable iff (!i_nrst)
        i_lock_response_error && i_posted_write_error
            |=> o_events[9] && o_events[8];
    endproperty
    a_errors: assert property (p_errors)
        else $error("error bits not set");

    property p_iso;
        @(posedge i_clk) disable iff (!i_nrst)
        1'b1 |=> o_events[7] == $past(|(i_iso_rx_events & i_iso_rx_mask))
            && o_events[6] == $past(|(i_iso_tx_events & i_iso_tx_mask));
    endproperty
    a_iso: assert property (p_iso)
        else $error("iso summary wrong");

    property p_pkt;
        @(posedge i_clk) disable iff (!i_nrst)
        i_response_packet_stored && i_request_packet_stored
            |=> o_events[5:4] == 2'h3;
    endproperty
    a_pkt: assert property (p_pkt)
        else $error("packet bits not set");

    property p_dma_done;
        @(posedge i_clk) disable iff (!i_nrst)
        i_arx_rsp_done && i_arx_rsp_irq_req && i_arx_req_done &&
        i_arx_req_irq_req && i_atx_rsp_done && i_atx_rsp_irq_req
            |=> o_events[3:1] == 3'h7;
    endproperty
    a_dma_done: assert property (p_dma_done)
        else $error("completion bits not set");

    property p_atx_req;
        @(posedge i_clk) disable iff (!i_nrst)
        i_atx_req_done && i_atx_req_irq_req |=> o_events[0];
    endproperty
    a_atx_req: assert property (p_atx_req)
        else $error("bit 0 not set");

    property p_no_req;
        @(posedge i_clk) disable iff (!i_nrst)
        i_atx_req_done && !i_atx_req_irq_req && !s_q.wr_pend
            |=> o_events[0] == $past(o_events[0]);
    endproperty
    a_no_req: assert property (p_no_req)
        else $error("bit 0 moved without request");

    property p_rd_masked;
        @(posedge i_clk) disable iff (!i_nrst)
        s_rd_clear |=> o_hrdata == {12'h000,
                                    o_events & $past(i_event_mask)};
    endproperty
    a_rd_masked: assert property (p_rd_masked)
        else $error("masked read wrong");

    property p_wr_set;
        @(posedge i_clk) disable iff (!i_nrst)
        s_wr_set ##1 i_hwdata[4] |=> o_events[4] ##1 o_events[4];
    endproperty
    a_wr_set: assert property (p_wr_set)
        else $error("set write failed");

    property p_wr_clear;
        @(posedge i_clk) disable iff (!i_nrst)
        s_wr_clear ##1 (i_hwdata[9] && !i_lock_response_error)
            |=> !o_events[9];
    endproperty
    a_wr_clear: assert property (p_wr_clear)
        else $error("clear write failed");

    property p_rd_set;
        @(posedge i_clk) disable iff (!i_nrst)
        s_rd_set |=> o_hrdata == {12'h000, o_events};
    endproperty
    a_rd_set: assert property (p_rd_set)
        else $error("raw read wrong");

    property p_id_sticky;
        @(posedge i_clk) disable iff (!i_nrst)
        i_identity_stream_done |=> o_events[15];
    endproperty
    a_id_sticky: assert property (p_id_sticky)
        else $error("bit 15 not set with bit 16");

    // latched bits only fall on a clear write or a bus reset
    property p_latched_hold;
        @(posedge i_clk) disable iff (!i_nrst)
        !s_q.wr_pend && !i_bus_reset |=>
            ((o_events & $past(o_events)) & lie_pkg::LIE_LATCHED) ==
            ($past(o_events) & lie_pkg::LIE_LATCHED);
    endproperty
    a_latched_hold: assert property (p_latched_hold)
        else $error("latched event bit dropped");

    // a set write cannot force the live summary bit
    property p_live_ro;
        @(posedge i_clk) disable iff (!i_nrst)
        s_wr_set ##1 !(|(i_iso_rx_events & i_iso_rx_mask))
            |=> !o_events[7];
    endproperty
    a_live_ro: assert property (p_live_ro)
        else $error("live bit 7 written");

endmodule

// [verilog/lie_pkg.sv]
package lie_pkg;

    // register byte addresses
    localparam logic [11:0] LIE_OFS_EVENT_SET   = 12'h080;
    localparam logic [11:0] LIE_OFS_EVENT_CLEAR = 12'h084;

    // event bit positions
    localparam int LIE_BIT_PHY_REQ        = 19;
    localparam int LIE_BIT_REG_FAIL       = 18;
    localparam int LIE_BIT_BUS_RESET      = 17;
    localparam int LIE_BIT_ID_DONE        = 16;
    localparam int LIE_BIT_ID_DONE_STICKY = 15;
    localparam int LIE_BIT_LOCK_ERR       = 9;
    localparam int LIE_BIT_POSTED_ERR     = 8;
    localparam int LIE_BIT_ISO_RX         = 7;
    localparam int LIE_BIT_ISO_TX         = 6;
    localparam int LIE_BIT_RSP_PKT        = 5;
    localparam int LIE_BIT_REQ_PKT        = 4;
    localparam int LIE_BIT_ARX_RSP        = 3;
    localparam int LIE_BIT_ARX_REQ        = 2;
    localparam int LIE_BIT_ATX_RSP        = 1;
    localparam int LIE_BIT_ATX_REQ        = 0;

    // event field width and latched / reserved masks
    localparam int          LIE_EV_W        = 20;
    localparam logic [19:0] LIE_LATCHED     = 20'hF833F;
    localparam logic [19:0] LIE_RESERVED    = 20'h07C00;
    localparam logic [19:0] LIE_EV_RESET    = 20'h00000;

    // number of isochronous contexts summarised per direction
    localparam int          LIE_ISO_CTX     = 8;

    // data phase targets
    localparam logic [1:0]  LIE_SEL_NONE    = 2'h0;
    localparam logic [1:0]  LIE_SEL_SET     = 2'h1;
    localparam logic [1:0]  LIE_SEL_CLEAR   = 2'h2;

    // ahb encodings
    localparam logic [1:0]  LIE_HTRANS_IDLE = 2'h0;
    localparam logic        LIE_HRESP_OKAY  = 1'b0;

endpackage

// [sim/lie_src_model.sv]
`timescale 1ns/1ps
// stand-in for phy status, bus init and dma engines
module lie_src_model (
    input  wire logic        i_clk,
    input  wire logic [19:0] i_fire,
    input  wire logic [3:0]  i_irq,
    output logic      [19:0] o_pulse,
    output logic      [3:0]  o_irq
);
    // one-cycle pulse a clock after each request; irq lines of unfired bits come out inverted
    always_ff @(posedge i_clk) begin
        o_pulse <= i_fire;
        o_irq   <= i_irq ^ ~i_fire[3:0];
    end
endmodule

// [sim/link_interrupt_event_low_bits_tb_top.sv]
`timescale 1ns/1ps
module link_interrupt_event_low_bits_tb_top;
    logic        clk, nrst, hsel, hwrite, hrdy, hresp;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, rnd, r, w;
    logic [19:0] fire, pulse, ev, mask, events, f;
    logic [3:0]  irq, pirq, q;
    logic [7:0]  rxe, rxm, txe, txm;
    int          failures, n_tests, i;

    lie_src_model lie_src_model_i (.i_clk(clk), .i_fire(fire), .i_irq(irq),
        .o_pulse(pulse), .o_irq(pirq));

    lie_events_low lie_events_low_i (.i_clk(clk), .i_nrst(nrst),
        .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy),
        .o_hresp(hresp), .i_phy_status_irq(pulse[19]),
        .i_register_access_fail(pulse[18]), .i_bus_reset(pulse[17]),
        .i_identity_stream_done(pulse[16]),
        .i_lock_response_error(pulse[9]), .i_posted_write_error(pulse[8]),
        .i_response_packet_stored(pulse[5]),
        .i_request_packet_stored(pulse[4]),
        .i_arx_rsp_done(pulse[3]), .i_arx_rsp_irq_req(pirq[3]),
        .i_arx_req_done(pulse[2]), .i_arx_req_irq_req(pirq[2]),
        .i_atx_rsp_done(pulse[1]), .i_atx_rsp_irq_req(pirq[1]),
        .i_atx_req_done(pulse[0]), .i_atx_req_irq_req(pirq[0]),
        .i_iso_rx_events(rxe), .i_iso_rx_mask(rxm), .i_iso_tx_events(txe),
        .i_iso_tx_mask(txm), .i_event_mask(mask), .o_events(events));

    // 20 MHz clock
    always #25 clk = ~clk;

    // pseudo-random source
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // expected latched events after one burst of source pulses
    function automatic logic [19:0] nxt(input logic [19:0] e,
                                        input logic [19:0] p,
                                        input logic [3:0]  rq);
        logic [19:0] s;
        s = p & 20'hF0330;
        s[3:0] = p[3:0] & rq;
        s[15] = p[16];
        e = e | s;
        if (p[17]) e[16] = 1'b0;
        return e;
    endfunction

    // expected read view including live iso summaries
    function automatic logic [31:0] view(input logic [19:0] e);
        return {12'h0, e[19:8], |(rxe & rxm), |(txe & txm), e[5:0]};
    endfunction

    task automatic end_sim;
        $display("tests=%0d failures=%0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // wait for hready at a rising edge, bounded
    task automatic wrdy;
        int k;
        k = 0;
        @(posedge clk);
        while (hrdy !== 1'b1) begin
            k++;
            if (k > 50) begin
                failures++;
                end_sim;
            end
            @(posedge clk);
        end
    endtask

    // one single ahb transfer, address phase then data phase
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        wrdy;
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        wrdy;
        rd = hrdata;
    endtask

    // one burst of source pulses, then settle
    task automatic pulse_src(input logic [19:0] p, input logic [3:0] rq);
        @(posedge clk);
        fire <= p;
        irq <= rq;
        @(posedge clk);
        fire <= 20'h0;
        repeat (3) @(posedge clk);
        ev = nxt(ev, p, rq);
        chk({12'h0, events}, view(ev));
    endtask

    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        end_sim;
    end

    initial begin
        clk = 0; nrst = 0; hsel = 0; hwrite = 0; htrans = 2'h0;
        haddr = 0; hwdata = 0; fire = 0; irq = 0; mask = 0; ev = 0;
        rxe = 0; rxm = 0; txe = 0; txm = 0; rnd = 32'h32;
        failures = 0; n_tests = 0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        chk({31'h0, hrdy}, 32'h1);
        chk({31'h0, hresp}, 32'h0);
        xfer(1'b0, 12'h080, 32'h0, r);
        chk(r, 32'h0);
        // set everything: reserved and live bits stay zero
        xfer(1'b1, 12'h080, 32'hFFFFFFFF, r);
        ev = 20'hF833F;
        xfer(1'b0, 12'h080, 32'h0, r);
        chk(r, view(ev));
        // unmapped place reads zero, write ignored
        xfer(1'b1, 12'h088, 32'hFFFFFFFF, r);
        xfer(1'b0, 12'h088, 32'h0, r);
        chk(r, 32'h0);
        xfer(1'b0, 12'h080, 32'h0, r);
        chk(r, view(ev));
        xfer(1'b1, 12'h084, 32'hFFFFFFFF, r);
        ev = 20'h0;
        xfer(1'b0, 12'h080, 32'h0, r);
        chk(r, 32'h0);
        // identity done then bus reset: sticky copy survives
        pulse_src(20'h10000, 4'h0);
        pulse_src(20'h20000, 4'h0);
        xfer(1'b0, 12'h080, 32'h0, r);
        chk(r, 32'h00028000);
        // completions without and with interrupt request
        pulse_src(20'h0000F, 4'h0);
        pulse_src(20'h0000F, 4'hE);
        for (i = 0; i < 24; i++) begin
            rnd = lfsr(rnd);
            rxe <= rnd[7:0];
            rxm <= rnd[15:8];
            txe <= rnd[23:16];
            txm <= rnd[31:24];
            rnd = lfsr(rnd);
            f = rnd[19:0] & 20'hF033F;
            q = rnd[23:20];
            pulse_src(f, q);
            xfer(1'b0, 12'h080, 32'h0, r);
            chk(r, view(ev));
            rnd = lfsr(rnd);
            mask <= rnd[19:0];
            xfer(1'b0, 12'h084, 32'h0, r);
            chk(r, view(ev) & {12'h0, mask});
            rnd = lfsr(rnd);
            xfer(1'b1, 12'h084, rnd, r);
            ev = ev & ~rnd[19:0];
            rnd = lfsr(rnd);
            w = rnd & lfsr(rnd);
            xfer(1'b1, 12'h080, w, r);
            ev = ev | (w[19:0] & 20'hF833F);
            xfer(1'b0, 12'h080, 32'h0, r);
            chk(r, view(ev));
        end
        end_sim;
    end
endmodule
